// ### ppi_pkg.sv
// pad pull-inhibit register bank: offsets, field positions, reset values, write masks
// assumes a 16-bit word-addressed register port on the system clock
// Function
// RULE1: every configurable pad has its own inhibit bit, settable independently; the emulation pads here share one bit (EMU_BIT).
// RULE2: test-reset pad pulldown is always on; no bit can turn it off.
// RULE3: first register bits 13..8 inhibit serial port 1 pins 5..0, reset 1.
// RULE4: first register bits 5..0 inhibit serial port 0 pins 5..0, reset 1.
// RULE5: pulldown inhibit bit 1 disables the pulldown, 0 keeps it enabled.
// RULE6: reserved bits 15-14, 7-6 (first) and 15, 7-6 (second) read 0.
// RULE7: second register bits 14,13 reset to 1; bits 12..8 reset to 0.
// RULE8: registers sit at word addresses 1C17h, 1C18h and 1C19h.
// RULE9: pullup inhibit bit 1 disables the pullup, 0 keeps it enabled.
// RULE10: second register bits 5..0 inhibit memory address pins 20..15, reset 1.
// RULE11: reserved writes are ignored; each bit drives its pad control continuously.
`default_nettype none
package ppi_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  localparam logic [15:0] SERIAL_OFFS   = 16'h1c17;
  localparam logic [15:0] CONTROL_OFFS  = 16'h1c18;
  localparam logic [15:0] PARALLEL_OFFS = 16'h1c19;

  localparam logic [15:0] SERIAL_RST   = 16'h3f3f;
  localparam logic [15:0] CONTROL_RST  = 16'h603f;
  localparam logic [15:0] PARALLEL_RST = 16'hfffc;

  localparam logic [15:0] SERIAL_WMASK   = 16'h3f3f;
  localparam logic [15:0] CONTROL_WMASK  = 16'h7f3f;
  localparam logic [15:0] PARALLEL_WMASK = 16'hfffc;

  localparam int unsigned SP1_LSB      = 8;
  localparam int unsigned SP0_LSB      = 0;
  localparam int unsigned SP_W         = 6;
  localparam int unsigned IRQ_B_BIT    = 14;
  localparam int unsigned IRQ_A_BIT    = 13;
  localparam int unsigned RESET_BIT    = 12;
  localparam int unsigned EMU_BIT      = 11;
  localparam int unsigned TDI_BIT      = 10;
  localparam int unsigned TMS_BIT      = 9;
  localparam int unsigned TCK_BIT      = 8;
  localparam int unsigned MEM_LSB      = 0;
  localparam int unsigned MEM_W        = 6;
  localparam int unsigned PAR_LSB      = 2;
  localparam int unsigned PAR_W        = 14;

  typedef enum logic [3:0] {
    PPI_SEL_NONE     = 4'h1,
    PPI_SEL_SERIAL   = 4'h2,
    PPI_SEL_CONTROL  = 4'h4,
    PPI_SEL_PARALLEL = 4'h8
  } ppi_sel_e;
endpackage
`default_nettype wire

// ### ppi_reg.sv
// one inhibit register with per-bit write mask and reset value
// assumes wr_en is already decoded for this register
`timescale 1ns/100ps
`default_nettype none
module ppi_reg #(
  parameter int unsigned WIDTH = 16,
  parameter logic [WIDTH-1:0] RST   = '0,
  parameter logic [WIDTH-1:0] WMASK = '0
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wdata,
  output var  logic [WIDTH-1:0] q_ff
);
  logic [WIDTH-1:0] nxt_q;

  always_comb
  begin
    nxt_q = q_ff;
    if (wr_en)
    begin
      // masked bits keep their value, so reserved positions stay 0
      nxt_q = (wdata & WMASK) | (q_ff & ~WMASK); // see RULE11 see RULE6
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q_ff <= RST;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end
endmodule // ppi_reg
`default_nettype wire

// ### ppi_regs.sv
// pad pull-inhibit register bank: three 16-bit registers on a plain register port,
// each writable bit held in a flop and driven straight to its pad pull control
// assumes one-cycle write and read strobes, never both at once, synchronous to clk
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ppi_regs #(
  parameter int unsigned ADDR_W = ppi_pkg::ADDR_W,
  parameter int unsigned DATA_W = ppi_pkg::DATA_W
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output var  logic [DATA_W-1:0] rdata_ff,
  output var  logic [5:0]        sp1_pd_off,
  output var  logic [5:0]        sp0_pd_off,
  output var  logic              irq_b_pu_off,
  output var  logic              irq_a_pu_off,
  output var  logic              reset_pad_pu_off,
  output var  logic              emulation_pads_pu_off,
  output var  logic              test_data_in_pu_off,
  output var  logic              test_mode_sel_pu_off,
  output var  logic              test_clock_pu_off,
  output var  logic [5:0]        mem_addr_pd_off,
  output var  logic [13:0]       parallel_pd_off,
  output var  logic              test_reset_pad_pd_on_ff
);

  // address decode shared by the write and read paths
  function automatic ppi_pkg::ppi_sel_e decode(input logic [ADDR_W-1:0] a);
    ppi_pkg::ppi_sel_e s;
    s = ppi_pkg::PPI_SEL_NONE;
    if (a == ADDR_W'(ppi_pkg::SERIAL_OFFS))
    begin
      s = ppi_pkg::PPI_SEL_SERIAL; // see RULE8
    end
    else if (a == ADDR_W'(ppi_pkg::CONTROL_OFFS))
    begin
      s = ppi_pkg::PPI_SEL_CONTROL; // see RULE8
    end
    else if (a == ADDR_W'(ppi_pkg::PARALLEL_OFFS))
    begin
      s = ppi_pkg::PPI_SEL_PARALLEL; // see RULE8
    end
    return s;
  endfunction

  ppi_pkg::ppi_sel_e sel;
  logic              wr_serial;
  logic              wr_control;
  logic              wr_parallel;
  logic [15:0]       serial_q;
  logic [15:0]       control_q;
  logic [15:0]       parallel_q;
  logic [15:0]       wdata16;
  logic [DATA_W-1:0] nxt_rdata;
  logic              nxt_test_reset_pad_pd_on;

  assign sel     = decode(addr);
  assign wdata16 = wdata[15:0];

  // write strobes per register; unmapped writes fall through and are dropped
  always_comb
  begin
    wr_serial   = 1'b0;
    wr_control  = 1'b0;
    wr_parallel = 1'b0;
    if (wr_stb)
    begin
      unique case (sel)
        ppi_pkg::PPI_SEL_SERIAL:   wr_serial   = 1'b1;
        ppi_pkg::PPI_SEL_CONTROL:  wr_control  = 1'b1;
        ppi_pkg::PPI_SEL_PARALLEL: wr_parallel = 1'b1;
        ppi_pkg::PPI_SEL_NONE:     wr_serial   = 1'b0;
      endcase
    end
  end

  // serial port pulldown inhibits, reset all 1 (pulldowns off)
  ppi_reg #(
    .WIDTH (16),
    .RST   (ppi_pkg::SERIAL_RST),   // see RULE3 see RULE4
    .WMASK (ppi_pkg::SERIAL_WMASK)  // see RULE6
  ) u_serial (
    .clk   (clk),
    .nrst  (nrst),
    .wr_en (wr_serial),
    .wdata (wdata16),
    .q_ff  (serial_q)
  );

  // interrupt, reset, emulation and test-port pullups plus upper address pulldowns
  ppi_reg #(
    .WIDTH (16),
    .RST   (ppi_pkg::CONTROL_RST),   // see RULE7 see RULE10
    .WMASK (ppi_pkg::CONTROL_WMASK)  // see RULE6
  ) u_control (
    .clk   (clk),
    .nrst  (nrst),
    .wr_en (wr_control),
    .wdata (wdata16),
    .q_ff  (control_q)
  );

  // parallel port pulldowns; two low bits reserved
  ppi_reg #(
    .WIDTH (16),
    .RST   (ppi_pkg::PARALLEL_RST),
    .WMASK (ppi_pkg::PARALLEL_WMASK)
  ) u_parallel (
    .clk   (clk),
    .nrst  (nrst),
    .wr_en (wr_parallel),
    .wdata (wdata16),
    .q_ff  (parallel_q)
  );

  // pad controls wired straight off the register flops; 1 turns the resistor off
  assign sp1_pd_off      = serial_q[ppi_pkg::SP1_LSB +: ppi_pkg::SP_W];  // see RULE3 see RULE5
  assign sp0_pd_off      = serial_q[ppi_pkg::SP0_LSB +: ppi_pkg::SP_W];  // see RULE4 see RULE5
  assign irq_b_pu_off          = control_q[ppi_pkg::IRQ_B_BIT]; // see RULE9 see RULE1
  assign irq_a_pu_off          = control_q[ppi_pkg::IRQ_A_BIT]; // see RULE9
  assign reset_pad_pu_off      = control_q[ppi_pkg::RESET_BIT]; // see RULE9
  assign emulation_pads_pu_off = control_q[ppi_pkg::EMU_BIT];   // see RULE9
  assign test_data_in_pu_off   = control_q[ppi_pkg::TDI_BIT];   // see RULE9
  assign test_mode_sel_pu_off  = control_q[ppi_pkg::TMS_BIT];   // see RULE9
  assign test_clock_pu_off     = control_q[ppi_pkg::TCK_BIT];   // see RULE9
  assign mem_addr_pd_off = control_q[ppi_pkg::MEM_LSB +: ppi_pkg::MEM_W]; // see RULE10 see RULE11
  assign parallel_pd_off = parallel_q[ppi_pkg::PAR_LSB +: ppi_pkg::PAR_W]; // see RULE11

  // read data stand for one cycle after the strobe; otherwise 0 so a stale value
  // never looks like an answer; unmapped reads return 0
  always_comb
  begin
    nxt_rdata = '0;
    if (rd_stb)
    begin
      unique case (sel)
        ppi_pkg::PPI_SEL_SERIAL:   nxt_rdata = DATA_W'(serial_q);   // see RULE6
        ppi_pkg::PPI_SEL_CONTROL:  nxt_rdata = DATA_W'(control_q);  // see RULE6
        ppi_pkg::PPI_SEL_PARALLEL: nxt_rdata = DATA_W'(parallel_q);
        ppi_pkg::PPI_SEL_NONE:     nxt_rdata = '0;
      endcase
    end
  end

  // test-reset pulldown has no control bit at all; flag held high for pad logic
  always_comb
  begin
    nxt_test_reset_pad_pd_on = 1'b1; // see RULE2
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_ff                <= '0;
      test_reset_pad_pd_on_ff <= 1'b1;
    end
    else
    begin
      rdata_ff                <= nxt_rdata;
      test_reset_pad_pd_on_ff <= nxt_test_reset_pad_pd_on;
    end
  end

endmodule // ppi_regs
`default_nettype wire

// ### ppi_regs_chk.sv
// checker for the pad pull-inhibit bank ports
// assumes binding into ppi_regs, one clock, async active-low reset
`timescale 1ns/100ps
`default_nettype none
module ppi_regs_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rdata_ff,
  input wire logic [5:0]  sp1_pd_off,
  input wire logic [5:0]  sp0_pd_off,
  input wire logic        irq_b_pu_off,
  input wire logic [5:0]  mem_addr_pd_off,
  input wire logic        test_reset_pad_pd_on_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_sp; wr_stb && addr == 16'h1c17 |=>
    {2'h0, sp1_pd_off, 2'h0, sp0_pd_off} == ($past(wdata) & 16'h3f3f); endproperty
  a_sp: assert property (p_sp) else $error("serial write");
  property p_mem; wr_stb && addr == 16'h1c18 |=>
    {10'h0, mem_addr_pd_off} == ($past(wdata) & 16'h003f); endproperty
  a_mem: assert property (p_mem) else $error("mem write");
  property p_irq; wr_stb && addr == 16'h1c18 |=>
    {1'b0, irq_b_pu_off, 14'h0} == ($past(wdata) & 16'h4000); endproperty
  a_irq: assert property (p_irq) else $error("irq write");
  property p_rdsp; rd_stb && addr == 16'h1c17 |=>
    rdata_ff == {2'h0, $past(sp1_pd_off), 2'h0, $past(sp0_pd_off)}; endproperty
  a_rdsp: assert property (p_rdsp) else $error("serial read");
  property p_rsvd; rd_stb && addr == 16'h1c18 |=> (rdata_ff & 16'h80c0) == 16'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read");
  property p_unm; rd_stb && (addr < 16'h1c17 || addr > 16'h1c19) |=> rdata_ff == 16'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_hold; !(wr_stb && addr == 16'h1c17) |=> $stable(sp0_pd_off) && $stable(sp1_pd_off);
  endproperty
  a_hold: assert property (p_hold) else $error("pads moved");
  property p_trst; test_reset_pad_pd_on_ff == 1'b1; endproperty
  a_trst: assert property (p_trst) else $error("test reset pulldown");
endmodule // ppi_regs_chk
bind ppi_regs ppi_regs_chk i_ppi_regs_chk (.clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb,
  .rdata_ff, .sp1_pd_off, .sp0_pd_off, .irq_b_pu_off, .mem_addr_pd_off, .test_reset_pad_pd_on_ff);
`default_nettype wire

// ### ppi_regs_tb.sv
// testbench for the pad pull-inhibit bank
// assumes ppi_regs with 16-bit address and data
`timescale 1ns/100ps
`default_nettype none
module ppi_regs_tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] addr = 16'h0;
  logic [15:0] wdata = 16'h0;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [15:0] rdata_ff;
  logic [5:0]  sp1, sp0, mem;
  logic [13:0] par;
  wire logic [6:0] ctl;
  logic        trst;
  logic [15:0] exp_q [3];
  logic [47:0] rows [8];
  int          err_total = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  always #4 clk = ~clk;
  ppi_regs i_ppi_regs (.clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb, .rdata_ff,
    .sp1_pd_off(sp1), .sp0_pd_off(sp0), .irq_b_pu_off(ctl[6]), .irq_a_pu_off(ctl[5]),
    .reset_pad_pu_off(ctl[4]), .emulation_pads_pu_off(ctl[3]), .test_data_in_pu_off(ctl[2]),
    .test_mode_sel_pu_off(ctl[1]), .test_clock_pu_off(ctl[0]), .mem_addr_pd_off(mem),
    .parallel_pd_off(par), .test_reset_pad_pd_on_ff(trst));
  task automatic complete_run();
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk_rd(input logic [15:0] e);
    samples_checked++;
    if (rdata_ff !== e)
    begin
      err_total++;
      $display("mismatch %0t read %h exp %h", $time, rdata_ff, e);
    end
  endtask
  task automatic chk_pad();
    samples_checked++;
    if ({2'h0, sp1, 2'h0, sp0, 1'b0, ctl, 2'h0, mem, par, 2'h0, trst} !==
        {exp_q[0], exp_q[1], exp_q[2], 1'b1})
    begin
      err_total++;
      $display("mismatch %0t pad state", $time);
    end
  endtask
  // tasks drive on a rising edge and return 1 ns after the taking edge,
  // so each request leaves one idle cycle; the no-gap case is written out below
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk_rd(e);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      err_total++;
      $display("mismatch %0t timeout", $time);
      complete_run();
    end
  end
  initial
  begin
    rows = '{{16'h1c17, 16'hffff, 16'h3f3f}, {16'h1c17, 16'h0000, 16'h0000},
             {16'h1c18, 16'hffff, 16'h7f3f}, {16'h1c18, 16'h0000, 16'h0000},
             {16'h1c19, 16'hffff, 16'hfffc}, {16'h1c19, 16'h0003, 16'h0000},
             {16'h1c1a, 16'hffff, 16'h0000}, {16'h1c16, 16'hffff, 16'h0000}};
    exp_q = '{16'h3f3f, 16'h603f, 16'hfffc};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk_pad();
    for (int i = 0; i < 3; i++)
      rd(16'(16'h1c17 + i), exp_q[i]);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      wr(rows[i][47:32], rows[i][31:16]);
      if (rows[i][47:32] inside {[16'h1c17:16'h1c19]})
        exp_q[rows[i][47:32] - 16'h1c17] = rows[i][15:0];
      chk_pad();
      rd(rows[i][47:32], rows[i][15:0]);
    end
    $display("test table done");
    wr(16'h1c17, 16'hea15);
    exp_q[0] = 16'h2a15;
    chk_pad();
    rd(16'h1c17, 16'h2a15);
    @(posedge clk);
    #1;
    chk_rd(16'h0);
    // write then read with no gap: the read must already see the new word
    @(posedge clk);
    addr <= 16'h1c19;
    wdata <= 16'h5a5a;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk_rd(16'h5a58);
    exp_q[2] = 16'h5a58;
    wr(16'h1c18, 16'hd515);
    exp_q[1] = 16'h5515;
    chk_pad();
    // reset taken mid-run; pads must fall back without waiting for another edge
    @(posedge clk);
    nrst <= 1'b0;
    #1;
    exp_q = '{16'h3f3f, 16'h603f, 16'hfffc};
    chk_pad();
    @(posedge clk);
    nrst <= 1'b1;
    rd(16'h1c18, 16'h603f);
    $display("test awkward done");
    complete_run();
  end
endmodule // ppi_regs_tb
`default_nettype wire
